// ### common/cqp_pkg.sv
// package for the caching and control mode-page policy block
// assumes a byte-serial page interface from the command interpreter
package cqp_pkg;
  localparam logic [5:0]  PAGE_CACHE      = 6'h08;
  localparam logic [7:0]  LEN_CACHE       = 8'h0A;
  localparam logic [5:0]  PAGE_CTRL       = 6'h0A;
  localparam logic [7:0]  LEN_CTRL        = 8'h06;
  localparam int          BIT_RCD         = 0;
  localparam int          BIT_MF          = 1;
  localparam int          BIT_WCE         = 2;
  localparam logic [3:0]  PRIO_EQUAL      = 4'h0;
  localparam logic [3:0]  PRIO_SOONER     = 4'h1;
  localparam logic [3:0]  PRIO_KEEP       = 4'hF;
  localparam logic [15:0] RST_DIS_THR     = 16'hFFFF;
  localparam logic [15:0] RST_MIN_PF      = 16'h0000;
  localparam logic [15:0] RST_MAX_PF      = 16'h00C0;
  localparam logic [15:0] RST_CEIL        = 16'h00C0;
  localparam logic [15:0] THR_ALWAYS      = 16'hFFFF;
  localparam logic [15:0] THR_NEVER       = 16'h0000;
  localparam logic [3:0]  RST_PRIO        = 4'h0;

  typedef struct packed {
    logic        write_cache_on;
    logic        prefetch_multiplier_sel;
    logic        read_cache_off;
    logic [3:0]  read_prio;
    logic [3:0]  write_prio;
    logic [15:0] dis_thr;
    logic [15:0] min_pf;
    logic [15:0] max_pf;
    logic [15:0] ceil_pf;
  } cqp_cache_t;

  typedef struct packed {
    logic [3:0] queue_alg;
    logic       queue_error_policy;
    logic       queue_disable;
  } cqp_ctrl_t;

  typedef struct packed {
    logic        pf_on;
    logic [15:0] pf_min;
    logic [15:0] pf_max;
    logic        from_cache_ok;
  } cqp_read_t;
endpackage

// ### core/cqp_policy.sv
// caching and control mode-page store plus per-command policy decisions
// assumes the command interpreter streams select pages byte by byte, one
// page at a time, and asks for sense bytes by index; single clock domain
// Notes on behaviour
// - caching page 08h, ten bytes, byte 2 bits
// - write cache off: good after medium write
// - write cache on: good after data received
// - write cache on forces write reallocation
// - multiplier selects blocks or transfer-length scale
// - read cache on: cache or medium allowed
// - read cache off: all reads from medium
// - read retention priority 0, 1, 0Fh
// - write retention priority 0, 1, 0Fh
// - skip prefetch when count exceeds threshold
// - threshold zero disables, FFFFh always enables
// - minimum prefetch honoured, default zero
// - maximum prefetch default C0h
// - maximum prefetch truncated to ceiling
// - control page 0Ah, six bytes
// - queue modifier zero keeps order, one reorders
// - queue error zero resumes, one aborts
module cqp_policy (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              sel_start,
  input  wire logic [5:0]        sel_page,
  input  wire logic              sel_valid,
  input  wire logic [7:0]        sel_byte,
  input  wire logic              sel_end,
  output logic                   sel_done,
  output logic                   sel_reject,
  input  wire logic              sense_req,
  input  wire logic [5:0]        sense_page,
  input  wire logic [3:0]        sense_idx,
  output logic                   sense_valid,
  output logic [7:0]             sense_byte,
  input  wire logic              rd_req,
  input  wire logic [15:0]       rd_blocks,
  output logic                   rd_valid,
  output cqp_pkg::cqp_read_t     rd_plan,
  input  wire logic              wr_req,
  input  wire logic              wr_on_medium,
  input  wire logic              wr_received,
  output logic                   wr_good,
  output logic                   write_realloc,
  output logic                   reorder_ok,
  output logic                   abort_on_error,
  output logic [1:0]             read_evict,
  output logic [1:0]             write_evict
);
  typedef enum logic [2:0] {
    CQP_IDLE  = 3'b001,
    CQP_LOAD  = 3'b010,
    CQP_CHECK = 3'b100
  } cqp_state_t;

  cqp_state_t          state_r;
  cqp_pkg::cqp_cache_t cache_r;
  cqp_pkg::cqp_cache_t cache_nxt;
  cqp_pkg::cqp_ctrl_t  ctrl_r;
  cqp_pkg::cqp_ctrl_t  ctrl_nxt;
  logic [5:0]          page_r;
  logic [3:0]          idx_r;
  logic                bad_r;
  logic                len_bad_r;
  logic                wr_pend_r;
  logic                auto_write_realloc;

  // 2-bit eviction class: 0 equal, 1 sooner, 2 keep, 3 other (advisory)
  function automatic logic [1:0] prio_class(input logic [3:0] p);
    if (p == cqp_pkg::PRIO_EQUAL) begin
      prio_class = 2'h0;
    end else if (p == cqp_pkg::PRIO_SOONER) begin
      prio_class = 2'h1;
    end else if (p == cqp_pkg::PRIO_KEEP) begin
      prio_class = 2'h2;
    end else begin
      prio_class = 2'h3;
    end
  endfunction

  // blocks or scale by transfer length, saturating at 16 bits
  function automatic logic [15:0] pf_count(input logic mf, input logic [15:0] f,
                                           input logic [15:0] len);
    logic [31:0] prod;
    prod = 32'h0;
    if (!mf) begin
      pf_count = f;
    end else begin
      prod = 32'(f) * 32'(len);
      pf_count = (prod[31:16] != 16'h0) ? 16'hFFFF : prod[15:0];
    end
  endfunction

  assign auto_write_realloc = 1'b0;

  // page load state
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= CQP_IDLE;
    end else begin
      unique case (state_r)
        CQP_IDLE: begin
          if (sel_start) begin
            state_r <= CQP_LOAD;
          end
        end
        CQP_LOAD: begin
          if (sel_end) begin
            state_r <= CQP_CHECK;
          end
        end
        CQP_CHECK: begin
          state_r <= CQP_IDLE;
        end
        default: state_r <= CQP_IDLE;
      endcase
    end
  end

  // staged copy of a page while loading
  always_ff @(posedge clk) begin
    if (reset) begin
      page_r    <= 6'h00;
      idx_r     <= 4'h0;
      bad_r     <= 1'b0;
      len_bad_r <= 1'b0;
      cache_nxt <= '0;
      ctrl_nxt  <= '0;
    end else if (state_r == CQP_IDLE && sel_start) begin
      page_r    <= sel_page;
      idx_r     <= 4'h0;
      bad_r     <= (sel_page != cqp_pkg::PAGE_CACHE) && (sel_page != cqp_pkg::PAGE_CTRL);
      len_bad_r <= 1'b0;
      cache_nxt <= cache_r;
      ctrl_nxt  <= ctrl_r;
    end else if (state_r == CQP_LOAD && sel_valid) begin
      idx_r <= idx_r + 4'h1;
      if (page_r == cqp_pkg::PAGE_CACHE) begin
        unique case (idx_r)
          4'h0: begin
            cache_nxt.write_cache_on          <= sel_byte[cqp_pkg::BIT_WCE];
            cache_nxt.prefetch_multiplier_sel <= sel_byte[cqp_pkg::BIT_MF];
            cache_nxt.read_cache_off          <= sel_byte[cqp_pkg::BIT_RCD];
          end
          4'h1: begin
            cache_nxt.read_prio  <= sel_byte[7:4];
            cache_nxt.write_prio <= sel_byte[3:0];
          end
          4'h2: cache_nxt.dis_thr[15:8] <= sel_byte;
          4'h3: cache_nxt.dis_thr[7:0]  <= sel_byte;
          4'h4: cache_nxt.min_pf[15:8]  <= sel_byte;
          4'h5: cache_nxt.min_pf[7:0]   <= sel_byte;
          4'h6: cache_nxt.max_pf[15:8]  <= sel_byte;
          4'h7: cache_nxt.max_pf[7:0]   <= sel_byte;
          4'h8: cache_nxt.ceil_pf[15:8] <= sel_byte;
          4'h9: cache_nxt.ceil_pf[7:0]  <= sel_byte;
          default: len_bad_r <= 1'b1;
        endcase
      end else if (page_r == cqp_pkg::PAGE_CTRL) begin
        unique case (idx_r)
          4'h0: bad_r <= bad_r | sel_byte[0];
          4'h1: begin
            ctrl_nxt.queue_alg          <= sel_byte[7:4];
            ctrl_nxt.queue_error_policy <= sel_byte[1];
            ctrl_nxt.queue_disable      <= sel_byte[0];
          end
          4'h2: bad_r <= bad_r | (sel_byte[7] | (|sel_byte[2:0]));
          4'h3: bad_r <= bad_r;
          4'h4: bad_r <= bad_r | (|sel_byte);
          4'h5: bad_r <= bad_r | (|sel_byte);
          default: len_bad_r <= 1'b1;
        endcase
      end
    end
  end

  // commit or reject the staged page
  always_ff @(posedge clk) begin
    if (reset) begin
      cache_r.write_cache_on          <= 1'b0;
      cache_r.prefetch_multiplier_sel <= 1'b0;
      cache_r.read_cache_off          <= 1'b0;
      cache_r.read_prio               <= cqp_pkg::RST_PRIO;
      cache_r.write_prio              <= cqp_pkg::RST_PRIO;
      cache_r.dis_thr                 <= cqp_pkg::RST_DIS_THR;
      cache_r.min_pf                  <= cqp_pkg::RST_MIN_PF;
      cache_r.max_pf                  <= cqp_pkg::RST_MAX_PF;
      cache_r.ceil_pf                 <= cqp_pkg::RST_CEIL;
      ctrl_r                          <= '0;
      sel_done                        <= 1'b0;
      sel_reject                      <= 1'b0;
    end else begin
      sel_done   <= (state_r == CQP_CHECK);
      sel_reject <= (state_r == CQP_CHECK) && (bad_r || len_bad_r);
      if (state_r == CQP_CHECK && !bad_r && !len_bad_r) begin
        if (page_r == cqp_pkg::PAGE_CACHE) begin
          cache_r <= cache_nxt;
        end else begin
          ctrl_r <= ctrl_nxt;
        end
      end
    end
  end

  // sense readback
  always_ff @(posedge clk) begin
    if (reset) begin
      sense_valid <= 1'b0;
      sense_byte  <= 8'h00;
    end else begin
      sense_valid <= sense_req;
      sense_byte  <= 8'h00;
      if (sense_req && sense_page == cqp_pkg::PAGE_CACHE) begin
        unique case (sense_idx)
          4'h0: sense_byte <= {2'b00, cqp_pkg::PAGE_CACHE};
          4'h1: sense_byte <= cqp_pkg::LEN_CACHE;
          4'h2: sense_byte <= {5'h00, cache_r.write_cache_on,
                               cache_r.prefetch_multiplier_sel, cache_r.read_cache_off};
          4'h3: sense_byte <= {cache_r.read_prio, cache_r.write_prio};
          4'h4: sense_byte <= cache_r.dis_thr[15:8];
          4'h5: sense_byte <= cache_r.dis_thr[7:0];
          4'h6: sense_byte <= cache_r.min_pf[15:8];
          4'h7: sense_byte <= cache_r.min_pf[7:0];
          4'h8: sense_byte <= cache_r.max_pf[15:8];
          4'h9: sense_byte <= cache_r.max_pf[7:0];
          4'hA: sense_byte <= cache_r.ceil_pf[15:8];
          4'hB: sense_byte <= cache_r.ceil_pf[7:0];
          default: sense_byte <= 8'h00;
        endcase
      end else if (sense_req && sense_page == cqp_pkg::PAGE_CTRL) begin
        unique case (sense_idx)
          4'h0: sense_byte <= {2'b00, cqp_pkg::PAGE_CTRL};
          4'h1: sense_byte <= cqp_pkg::LEN_CTRL;
          4'h3: sense_byte <= {ctrl_r.queue_alg, 2'b00,
                               ctrl_r.queue_error_policy, ctrl_r.queue_disable};
          default: sense_byte <= 8'h00;
        endcase
      end
    end
  end

  // read plan: prefetch gate, sizing, cache use
  always_ff @(posedge clk) begin
    logic [15:0] mx;
    mx = 16'h0;
    if (reset) begin
      rd_valid <= 1'b0;
      rd_plan  <= '0;
    end else begin
      rd_valid <= rd_req;
      if (rd_req) begin
        mx = pf_count(cache_r.prefetch_multiplier_sel, cache_r.max_pf, rd_blocks);
        if (mx > cache_r.ceil_pf) begin
          mx = cache_r.ceil_pf;
        end
        rd_plan.pf_on <= (cache_r.dis_thr != cqp_pkg::THR_NEVER) &&
                         ((cache_r.dis_thr == cqp_pkg::THR_ALWAYS) ||
                          (rd_blocks <= cache_r.dis_thr));
        rd_plan.pf_min <= pf_count(cache_r.prefetch_multiplier_sel,
                                   cache_r.min_pf, rd_blocks);
        rd_plan.pf_max <= mx;
        rd_plan.from_cache_ok <= !cache_r.read_cache_off;
      end
    end
  end

  // write completion status
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_pend_r <= 1'b0;
      wr_good   <= 1'b0;
    end else begin
      wr_good <= 1'b0;
      if (wr_req) begin
        wr_pend_r <= 1'b1;
      end else if (wr_pend_r) begin
        if (cache_r.write_cache_on ? wr_received : wr_on_medium) begin
          wr_good   <= 1'b1;
          wr_pend_r <= 1'b0;
        end
      end
    end
  end

  // static policy outputs
  always_ff @(posedge clk) begin
    if (reset) begin
      write_realloc  <= 1'b0;
      reorder_ok     <= 1'b0;
      abort_on_error <= 1'b0;
      read_evict     <= 2'h0;
      write_evict    <= 2'h0;
    end else begin
      write_realloc  <= cache_r.write_cache_on | auto_write_realloc;
      reorder_ok     <= (ctrl_r.queue_alg == 4'h1);
      abort_on_error <= ctrl_r.queue_error_policy;
      read_evict     <= prio_class(cache_r.read_prio);
      write_evict    <= prio_class(cache_r.write_prio);
    end
  end

  property p_reject_keeps;
    @(posedge clk) disable iff (reset)
      (state_r == CQP_CHECK && (bad_r || len_bad_r)) |=> $stable(ctrl_r) && $stable(cache_r);
  endproperty
  a_reject_keeps: assert property (p_reject_keeps) else $error("rejected page changed state");

  property p_realloc;
    @(posedge clk) disable iff (reset) cache_r.write_cache_on |=> write_realloc;
  endproperty
  a_realloc: assert property (p_realloc) else $error("realloc not forced");

  property p_no_cache_read;
    @(posedge clk) disable iff (reset)
      (rd_req && cache_r.read_cache_off) |=> rd_valid && !rd_plan.from_cache_ok;
  endproperty
  a_no_cache_read: assert property (p_no_cache_read) else $error("cache used when off");

  property p_cache_read;
    @(posedge clk) disable iff (reset)
      (rd_req && !cache_r.read_cache_off) |=> rd_plan.from_cache_ok;
  endproperty
  a_cache_read: assert property (p_cache_read) else $error("cache not allowed");

  property p_thr_zero;
    @(posedge clk) disable iff (reset)
      (rd_req && cache_r.dis_thr == 16'h0000) |=> !rd_plan.pf_on;
  endproperty
  a_thr_zero: assert property (p_thr_zero) else $error("prefetch with zero threshold");

  property p_thr_skip;
    @(posedge clk) disable iff (reset)
      (rd_req && rd_blocks > cache_r.dis_thr) |=> !rd_plan.pf_on;
  endproperty
  a_thr_skip: assert property (p_thr_skip) else $error("prefetch on long read");

  property p_ceiling;
    @(posedge clk) disable iff (reset)
      rd_req |=> rd_plan.pf_max <= $past(cache_r.ceil_pf);
  endproperty
  a_ceiling: assert property (p_ceiling) else $error("max prefetch above ceiling");

  property p_wt_wait;
    @(posedge clk) disable iff (reset)
      (wr_pend_r && !cache_r.write_cache_on && !wr_on_medium && !wr_req) |=> !wr_good;
  endproperty
  a_wt_wait: assert property (p_wt_wait) else $error("good before medium write");

  property p_wb_fast;
    @(posedge clk) disable iff (reset)
      (wr_pend_r && !wr_req && cache_r.write_cache_on && wr_received) |=> wr_good;
  endproperty
  a_wb_fast: assert property (p_wb_fast) else $error("no good after receipt");

  property p_queue;
    @(posedge clk) disable iff (reset) (ctrl_r.queue_alg == 4'h0) |=> !reorder_ok;
  endproperty
  a_queue: assert property (p_queue) else $error("reorder with modifier zero");

  c_reject: cover property (@(posedge clk) sel_reject);
  c_commit: cover property (@(posedge clk) sel_done && !sel_reject);
  c_pf:     cover property (@(posedge clk) rd_valid && rd_plan.pf_on);
  c_wgood:  cover property (@(posedge clk) wr_good);
endmodule

// ### sim/cqp_host.sv
// host model: mode select and mode sense sequences
// assumes the policy block's select and sense handshakes
module cqp_host (
  input  wire logic       clk,
  output logic            sel_start,
  output logic [5:0]      sel_page,
  output logic            sel_valid,
  output logic [7:0]      sel_byte,
  output logic            sel_end,
  input  wire logic       sel_done,
  input  wire logic       sel_reject,
  output logic            sense_req,
  output logic [5:0]      sense_page,
  output logic [3:0]      sense_idx,
  input  wire logic       sense_valid,
  input  wire logic [7:0] sense_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sel_start <= 1'h0;
    sel_page <= 6'h00;
    sel_valid <= 1'h0;
    sel_byte <= 8'h00;
    sel_end <= 1'h0;
    sense_req <= 1'h0;
    sense_page <= 6'h00;
    sense_idx <= 4'h0;
  end
  // unsupported fields go out as given; only reject tests set them
  task automatic sel(input logic [5:0] pg, input logic [7:0] b [12], input int n,
                     output logic rej, output logic ok);
    rej = 1'h0;
    ok = 1'h0;
    @(posedge clk);
    sel_start <= 1'h1;
    sel_page <= pg;
    @(posedge clk);
    sel_start <= 1'h0;
    sel_page <= ~pg;
    for (int i = 0; i < n; i++) begin
      sel_valid <= 1'h1;
      sel_byte <= b[i];
      @(posedge clk);
    end
    sel_valid <= 1'h0;
    sel_byte <= ~sel_byte;
    sel_end <= 1'h1;
    @(posedge clk);
    sel_end <= 1'h0;
    for (int i = 0; i < 8 && !ok; i++) begin
      @(posedge clk);
      if (sel_done === 1'h1) begin
        ok = 1'h1;
        rej = sel_reject;
      end
    end
  endtask
  task automatic sense(input logic [5:0] pg, input logic [3:0] idx,
                       output logic [7:0] d, output logic ok);
    ok = 1'h0;
    d = 8'h00;
    @(posedge clk);
    sense_req <= 1'h1;
    sense_page <= pg;
    sense_idx <= idx;
    @(posedge clk);
    sense_req <= 1'h0;
    sense_idx <= ~idx;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge clk);
      if (sense_valid === 1'h1) begin
        ok = 1'h1;
        d = sense_byte;
      end
    end
  endtask
endmodule

// ### sim/cqp_policy_test.sv
// bench: defaults, table of caching pages, then write, queue and reset tests
// assumes cqp_host drives select and sense
module cqp_policy_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0]  b2, b3;
    logic [15:0] thr, mn, mx, cl, blk;
    logic        on;
  } cqp_row_t;
  logic clk, reset, sel_start, sel_valid, sel_end, sel_done, sel_reject;
  logic sense_req, sense_valid, rd_req, rd_valid, wr_req, wr_on_medium;
  logic wr_received, wr_good, write_realloc, reorder_ok, abort_on_error;
  logic [5:0] sel_page, sense_page;
  logic [7:0] sel_byte, sense_byte, d;
  logic [3:0] sense_idx;
  logic [15:0] rd_blocks;
  logic [1:0] read_evict, write_evict;
  cqp_pkg::cqp_read_t rd_plan;
  int error_cnt = 0;
  int checks_done = 0;
  logic [7:0] pb [12];
  logic ok, rej, g;
  cqp_row_t rows [5] = '{
    '{8'h04, 8'h0F, 16'hFFFF, 16'h0004, 16'h0100, 16'h00C0, 16'hFFFF, 1'h1},
    '{8'h03, 8'h1F, 16'h0010, 16'h0002, 16'h0008, 16'h0100, 16'h0010, 1'h1},
    '{8'h00, 8'hF1, 16'h0010, 16'h0001, 16'h0001, 16'h0001, 16'h0011, 1'h0},
    '{8'h06, 8'h35, 16'h0000, 16'h0001, 16'h0001, 16'h0001, 16'h0000, 1'h0},
    '{8'h02, 8'h00, 16'hFFFF, 16'h1000, 16'h1000, 16'h2000, 16'h0010, 1'h1}};
  logic [7:0] dflt [20] = '{8'h08, 8'h0A, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00,
    8'h00, 8'hC0, 8'h00, 8'hC0, 8'h0A, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] qv [3] = '{8'h20, 8'h00, 8'h12};
  int bi [7] = '{0, 2, 2, 4, 5, 0, 6};
  logic [7:0] bv [7] = '{8'h01, 8'h80, 8'h07, 8'h01, 8'h01, 8'h01, 8'h00};

  cqp_policy u_cqp_policy (.clk, .reset, .sel_start, .sel_page, .sel_valid, .sel_byte,
    .sel_end, .sel_done, .sel_reject, .sense_req, .sense_page, .sense_idx, .sense_valid,
    .sense_byte, .rd_req, .rd_blocks, .rd_valid, .rd_plan, .wr_req, .wr_on_medium,
    .wr_received, .wr_good, .write_realloc, .reorder_ok, .abort_on_error, .read_evict,
    .write_evict);
  cqp_host u_cqp_host (.clk, .sel_start, .sel_page, .sel_valid, .sel_byte, .sel_end,
    .sel_done, .sel_reject, .sense_req, .sense_page, .sense_idx, .sense_valid, .sense_byte);

  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic need(input logic k);
    if (k !== 1'h1) begin
      error_cnt++;
      $display("[FAIL] handshake expected 1 seen %b", k);
      test_done();
    end
  endtask
  task automatic sel(input logic [5:0] pg, input int n);
    u_cqp_host.sel(pg, pb, n, rej, ok);
    need(ok);
  endtask
  task automatic rd(input logic [15:0] n, output cqp_pkg::cqp_read_t p);
    ok = 1'h0;
    @(posedge clk);
    rd_req <= 1'h1;
    rd_blocks <= n;
    @(posedge clk);
    rd_req <= 1'h0;
    rd_blocks <= ~n;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge clk);
      if (rd_valid === 1'h1) begin
        ok = 1'h1;
        p = rd_plan;
      end
    end
    need(ok);
  endtask
  task automatic wr_step(input logic rq, input logic rcv, input logic med);
    g = 1'h0;
    if (rq) begin
      @(posedge clk);
      wr_req <= 1'h1;
      @(posedge clk);
      wr_req <= 1'h0;
    end
    @(posedge clk);
    wr_received <= rcv;
    wr_on_medium <= med;
    @(posedge clk);
    wr_received <= 1'h0;
    wr_on_medium <= 1'h0;
    repeat (3) begin
      @(posedge clk);
      if (wr_good === 1'h1) g = 1'h1;
    end
  endtask
  function automatic logic [1:0] ev(input logic [3:0] v);
    if (v == 4'h0) return 2'h0;
    if (v == 4'h1) return 2'h1;
    return (v == 4'hF) ? 2'h2 : 2'h3;
  endfunction
  function automatic logic [15:0] scale(input logic [15:0] f, input logic m,
                                        input logic [15:0] n);
    logic [31:0] x;
    x = 32'(f) * 32'(n);
    if (!m) return f;
    return (x > 32'h0000FFFF) ? 16'hFFFF : x[15:0];
  endfunction

  initial begin
    cqp_pkg::cqp_read_t p;
    logic [15:0] mn, mx;
    reset <= 1'h1;
    rd_req <= 1'h0;
    rd_blocks <= 16'h0000;
    wr_req <= 1'h0;
    wr_on_medium <= 1'h0;
    wr_received <= 1'h0;
    repeat (12) @(posedge clk);
    reset <= 1'h0;
    chk("levels", {write_realloc, reorder_ok, abort_on_error, read_evict, write_evict}, 0);
    for (int i = 0; i < 20; i++) begin
      u_cqp_host.sense(i < 12 ? cqp_pkg::PAGE_CACHE : cqp_pkg::PAGE_CTRL,
                       4'(i < 12 ? i : i - 12), d, ok);
      need(ok);
      chk("sense", (i % 12 == 0) ? d & 8'h3F : d, dflt[i]);
    end
    rd(16'h0010, p);
    chk("dflt_plan", p, {1'h1, 16'h0000, 16'h00C0, 1'h1});
    $display("test defaults done");
    foreach (rows[r]) begin
      for (int k = 0; k < 10; k++) pb[k] = rows[r][96 - 8 * k -: 8];
      sel(cqp_pkg::PAGE_CACHE, 10);
      chk("rej", rej, 1'h0);
      rd(rows[r].blk, p);
      mn = scale(rows[r].mn, rows[r].b2[1], rows[r].blk);
      mx = scale(rows[r].mx, rows[r].b2[1], rows[r].blk);
      if (mx > rows[r].cl) mx = rows[r].cl;
      chk("pf_on", {p.pf_on, p.from_cache_ok}, {rows[r].on, ~rows[r].b2[0]});
      if (rows[r].on) chk("pf_size", {p.pf_min, p.pf_max}, {mn, mx});
      chk("class", {write_realloc, read_evict, write_evict},
          {rows[r].b2[2], ev(rows[r].b3[7:4]), ev(rows[r].b3[3:0])});
    end
    $display("test table done");
    pb[0] = 8'h00;
    sel(cqp_pkg::PAGE_CACHE, 1);
    wr_step(1'h1, 1'h1, 1'h0);
    chk("good_early", {g, write_realloc}, 2'h0);
    wr_step(1'h0, 1'h0, 1'h1);
    chk("good_medium", g, 1'h1);
    pb[0] = 8'h04;
    sel(cqp_pkg::PAGE_CACHE, 1);
    wr_step(1'h1, 1'h1, 1'h0);
    chk("good_cached", {g, write_realloc}, 2'h3);
    $display("test writes done");
    foreach (qv[k]) begin
      pb = '{default: 8'h00};
      pb[1] = qv[k];
      sel(cqp_pkg::PAGE_CTRL, 6);
      repeat (2) @(posedge clk);
      chk("queue", {reorder_ok, abort_on_error}, {qv[k][7:4] == 4'h1, qv[k][1]});
    end
    foreach (bi[k]) begin
      pb = '{default: 8'h00};
      pb[bi[k]] = bv[k];
      sel(k == 5 ? 6'h3F : cqp_pkg::PAGE_CTRL, (k == 6) ? 7 : 6);
      repeat (2) @(posedge clk);
      chk("reject", {rej, reorder_ok, abort_on_error}, 3'h7);
    end
    $display("test control done");
    reset <= 1'h1;
    repeat (2) @(posedge clk);
    reset <= 1'h0;
    chk("rst_levels", {write_realloc, reorder_ok, abort_on_error}, 3'h0);
    rd(16'h0010, p);
    chk("rst_plan", p, {1'h1, 16'h0000, 16'h00C0, 1'h1});
    $display("test reset done");
    test_done();
  end
endmodule
